// [src/timeout_count_if.sv]
// Signals between the control logic and the period counter
`timescale 1ns/1ps
interface timeout_count_if;
   logic restart;
   logic [3:0] period_select;
   logic timeout;

   // Control side steers, counter side reports
   modport ctrl (output restart, output period_select, input timeout);
   modport counter (input restart, input period_select, output timeout);
endinterface

// [src/watchdog_period_counter.sv]
// Oscillator synchroniser and time-out counter of the watchdog
`timescale 1ns/1ps
module watchdog_period_counter #(
   parameter int unsigned BASE_CYCLES = wdt_pkg::TIMEOUT_BASE_CYCLES
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // Watchdog oscillator pin
   input wire logic osc_i,
   // Control link
   timeout_count_if.counter cnt_if
);

   logic [2:0] osc_sync;
   logic osc_level;
   wdt_pkg::count_t count;
   logic timeout_q;
   logic [3:0] sel_eff;
   wdt_pkg::count_t last_count;
   logic osc_rise;

   // Oscillator pin, three stages; stage 0 feeds stage 1 only
   always_ff @(posedge mclk_i)
   begin
      if (!reset_n_i)
         osc_sync <= 3'h0;
      else
         osc_sync <= {osc_sync[1], osc_sync[0], osc_i};
   end

   // A rise to high counts once stages 1 and 2 agree; a fall only updates the level
   assign osc_rise = (osc_sync[1] == osc_sync[2]) & osc_sync[1] & ~osc_level;

   always_ff @(posedge mclk_i)
   begin
      if (!reset_n_i)
         osc_level <= 1'b0;
      else if (osc_sync[1] == osc_sync[2])
         osc_level <= osc_sync[1];
   end

   // R12 reserved codes clamp
   assign sel_eff = (cnt_if.period_select > wdt_pkg::PERIOD_SELECT_MAX) ? wdt_pkg::PERIOD_SELECT_MAX
                                                                       : cnt_if.period_select;
   // R11 doubling per code
   assign last_count = wdt_pkg::count_t'((BASE_CYCLES << sel_eff) - 1);

   // R13 counts oscillator edges
   // R14 restart clears count
   always_ff @(posedge mclk_i)
   begin
      if (!reset_n_i || cnt_if.restart)
         count <= '0;
      else if (osc_rise)
         count <= (count >= last_count) ? '0 : wdt_pkg::count_t'(count + 1'b1);
   end

   // R17 time-out leaves as a CPU-clock pulse
   always_ff @(posedge mclk_i)
   begin
      if (!reset_n_i || cnt_if.restart)
         timeout_q <= 1'b0;
      else
         timeout_q <= osc_rise & (count >= last_count);
   end

   assign cnt_if.timeout = timeout_q;

endmodule

// [src/watchdog_timer_control.sv]
// Watchdog timer control: APB registers, mode logic, unlock window and reset cause
//
// Function
// R1 - Time-out in an interrupt mode sets the interrupt flag.
// R2 - Flag clears on vector taken or on software writing one.
// R3 - Interrupt requested only with global enable, local enable and flag set.
// R4 - Mode from reset and interrupt enables; fuse forces reset mode.
// R5 - Combined mode: first time-out flags; vector clears flag and enable.
// R6 - Combined mode: unserviced flag at next time-out gives system reset.
// R7 - Software re-enables interrupt after each one, outside the service routine.
// R8 - Clearing reset enable or changing period needs the unlock bit.
// R9 - Unlock bit clears itself four CPU cycles after being set.
// R10 - Reset-cause flag holds reset enable at one.
// R11 - Four-bit period code picks 2048 to 1048576 oscillator cycles.
// R12 - Reserved period codes act as the highest valid code.
// R13 - Counter runs from a separate oscillator, nominally 128 kHz.
// R14 - Kick, disable and chip reset restart the counter.
// R15 - Software unlocks with one write, then reconfigures within four cycles.
// R16 - Watchdog reset sets cause flag; only power-on or zero write clears.
// R17 - Time-out events are synchronised to the CPU clock before use.
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module watchdog_timer_control #(
   parameter int unsigned TIMEOUT_BASE_CYCLES = wdt_pkg::TIMEOUT_BASE_CYCLES
) (
   // Clock and power-on reset
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Processor core
   input wire logic global_irq_enable_i,
   input wire logic irq_vector_taken_i,
   input wire logic kick_instruction_i,
   output logic timeout_irq_o,
   // Fuse, oscillator and system reset
   input wire logic always_on_fuse_i,
   input wire logic wdt_osc_i,
   output logic system_reset_o
);

   // Register state
   logic timeout_irq_flag;
   logic timeout_irq_enable;
   logic timeout_reset_enable;
   logic change_unlock_bit;
   logic [2:0] unlock_count;
   logic [3:0] period_select;
   logic dog_reset_cause_flag;

   // Bus answer and core outputs
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic timeout_irq;
   logic system_reset;

   // Next values
   logic next_irq_flag;
   logic next_irq_enable;
   logic next_reset_enable;
   logic next_unlock;
   logic [2:0] next_unlock_count;
   logic [3:0] next_period_select;
   logic next_cause_flag;

   // Time-out action decode
   logic to_irq;
   logic to_reset;

   timeout_count_if cnt_if ();

   watchdog_period_counter #(
      .BASE_CYCLES(TIMEOUT_BASE_CYCLES)
   ) u_counter (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .osc_i(wdt_osc_i),
      .cnt_if(cnt_if)
   );

   // APB phase and address decode
   wire apb_setup = psel_i & ~penable_i;
   wire apb_commit = psel_i & penable_i & pready;
   wire hit_ctrl = (paddr_i == wdt_pkg::CTRL_STATUS_ADDR);
   wire hit_cause = (paddr_i == wdt_pkg::RESET_CAUSE_ADDR);
   wire hit_any = hit_ctrl | hit_cause;

   // Writes need the low byte lane; other lanes hold nothing
   wire ctrl_wr = apb_commit & pwrite_i & hit_ctrl & pstrb_i[0];
   wire cause_wr = apb_commit & pwrite_i & hit_cause & pstrb_i[0];

   // Written field values
   wire [7:0] wbyte = pwdata_i[7:0];
   wire wr_irq_flag = wbyte[wdt_pkg::IRQ_FLAG_BIT];
   wire wr_irq_enable = wbyte[wdt_pkg::IRQ_ENABLE_BIT];
   wire wr_unlock = wbyte[wdt_pkg::UNLOCK_BIT];
   wire wr_reset_enable = wbyte[wdt_pkg::RESET_ENABLE_BIT];
   wire [3:0] wr_period = {wbyte[wdt_pkg::PERIOD_HI_BIT], wbyte[wdt_pkg::PERIOD_LO_MSB:0]};
   wire wr_cause_flag = wbyte[wdt_pkg::CAUSE_FLAG_BIT];

   // Chip reset from our own pulse restores the control state
   wire chip_reset = system_reset;

   // R10 cause flag overrides reset enable
   wire reset_enable_eff = timeout_reset_enable | dog_reset_cause_flag | always_on_fuse_i;

   // R4 mode selection, fuse forces reset mode
   wire [1:0] mode_code = {reset_enable_eff, timeout_irq_enable};
   wire wdt_pkg::mode_e mode = always_on_fuse_i ? wdt_pkg::MODE_RESET : wdt_pkg::mode_e'(mode_code);
   wire running = (mode != wdt_pkg::MODE_STOPPED);

   // R14 restart on kick, disable or chip reset
   assign cnt_if.restart = kick_instruction_i | ~running | chip_reset;
   assign cnt_if.period_select = period_select;

   // Vector taken only matters while the flag is pending
   wire vector_ack = irq_vector_taken_i & timeout_irq_flag;

   // Unlock opens only when the unlock and reset enable bits are written together
   wire unlock_start = ctrl_wr & wr_unlock & wr_reset_enable;

   // Time-out action per mode
   always_comb
   begin
      to_irq = 1'b0;
      to_reset = 1'b0;
      if (cnt_if.timeout)
      begin
         unique case (mode)
            wdt_pkg::MODE_STOPPED:
            begin
               to_irq = 1'b0;
            end
            // R1 interrupt mode flags
            wdt_pkg::MODE_IRQ:
            begin
               to_irq = 1'b1;
            end
            wdt_pkg::MODE_RESET:
            begin
               to_reset = 1'b1;
            end
            wdt_pkg::MODE_IRQ_RESET:
            begin
               // R6 unserviced flag resets
               if (timeout_irq_flag)
                  to_reset = 1'b1;
               // R5 first time-out flags
               else
                  to_irq = 1'b1;
            end
         endcase
      end
   end

   // Interrupt flag; a time-out wins over any clear in the same cycle
   always_comb
   begin
      next_irq_flag = timeout_irq_flag;
      if (chip_reset)
         next_irq_flag = 1'b0;
      // R1 set on time-out
      else if (to_irq)
         next_irq_flag = 1'b1;
      // R2 vector or write-one clears
      else if (vector_ack || (ctrl_wr && wr_irq_flag))
         next_irq_flag = 1'b0;
   end

   // Interrupt enable; software write is taken after the hardware clear
   always_comb
   begin
      next_irq_enable = timeout_irq_enable;
      if (chip_reset)
         next_irq_enable = 1'b0;
      else if (ctrl_wr)
         next_irq_enable = wr_irq_enable;
      // R5 vector drops to reset mode
      else if (vector_ack && reset_enable_eff)
         next_irq_enable = 1'b0;
   end

   // Reset enable: set freely, cleared only inside the unlock window
   always_comb
   begin
      next_reset_enable = timeout_reset_enable;
      if (chip_reset)
         next_reset_enable = 1'b0;
      // R10 held while cause flag set
      else if (dog_reset_cause_flag)
         next_reset_enable = 1'b1;
      // R8 clear needs unlock
      else if (ctrl_wr && change_unlock_bit)
         next_reset_enable = wr_reset_enable;
      else if (ctrl_wr)
         next_reset_enable = timeout_reset_enable | wr_reset_enable;
   end

   // Period select changes only inside the unlock window
   always_comb
   begin
      next_period_select = period_select;
      if (chip_reset)
         next_period_select = wdt_pkg::PERIOD_SELECT_RESET;
      // R8 period change needs unlock
      else if (ctrl_wr && change_unlock_bit)
         next_period_select = wr_period;
   end

   // Unlock bit and its cycle counter; a write beats the expiry
   always_comb
   begin
      next_unlock = change_unlock_bit;
      next_unlock_count = unlock_count;
      if (chip_reset)
      begin
         next_unlock = 1'b0;
         next_unlock_count = 3'h0;
      end
      else if (ctrl_wr)
      begin
         next_unlock = unlock_start;
         next_unlock_count = unlock_start ? wdt_pkg::UNLOCK_CYCLES : 3'h0;
      end
      // R9 self clear after four cycles
      else if (change_unlock_bit && unlock_count == wdt_pkg::UNLOCK_LAST)
      begin
         next_unlock = 1'b0;
         next_unlock_count = 3'h0;
      end
      else if (change_unlock_bit)
      begin
         next_unlock_count = unlock_count - 3'h1;
      end
   end

   // Cause flag survives chip reset; set wins over a zero write
   always_comb
   begin
      next_cause_flag = dog_reset_cause_flag;
      // R16 set by watchdog reset
      if (to_reset)
         next_cause_flag = 1'b1;
      else if (cause_wr && !wr_cause_flag)
         next_cause_flag = 1'b0;
   end

   // Control register state
   always_ff @(posedge mclk_i)
   begin
      if (!reset_n_i)
      begin
         timeout_irq_flag <= 1'b0;
         timeout_irq_enable <= 1'b0;
         timeout_reset_enable <= 1'b0;
         change_unlock_bit <= 1'b0;
         unlock_count <= 3'h0;
         period_select <= wdt_pkg::PERIOD_SELECT_RESET;
      end
      else
      begin
         timeout_irq_flag <= next_irq_flag;
         timeout_irq_enable <= next_irq_enable;
         timeout_reset_enable <= next_reset_enable;
         change_unlock_bit <= next_unlock;
         unlock_count <= next_unlock_count;
         period_select <= next_period_select;
      end
   end

   // Only power-on reset or a zero write clears the cause flag
   always_ff @(posedge mclk_i)
   begin
      if (!reset_n_i)
         dog_reset_cause_flag <= 1'b0;
      else
         dog_reset_cause_flag <= next_cause_flag;
   end

   // Read views; reserved bits read zero
   wire [7:0] ctrl_view = {timeout_irq_flag, timeout_irq_enable, period_select[3], change_unlock_bit,
                           reset_enable_eff, period_select[2:0]};
   wire [7:0] cause_view = {4'h0, dog_reset_cause_flag, 3'h0};
   wire [7:0] read_byte = hit_ctrl ? ctrl_view : (hit_cause ? cause_view : wdt_pkg::BYTE_ZERO);

   // APB answer: ready in the first access cycle, no wait states
   always_ff @(posedge mclk_i)
   begin
      if (!reset_n_i)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= wdt_pkg::WORD_ZERO;
      end
      else
      begin
         pready <= apb_setup;
         pslverr <= apb_setup & ~hit_any;
         prdata <= (apb_setup && !pwrite_i) ? {24'h000000, read_byte} : wdt_pkg::WORD_ZERO;
      end
   end

   // Interrupt request from next state, so it drops the edge the flag clears
   always_ff @(posedge mclk_i)
   begin
      if (!reset_n_i)
      begin
         timeout_irq <= 1'b0;
         system_reset <= 1'b0;
      end
      else
      begin
         // R3 global, local enable and flag
         timeout_irq <= global_irq_enable_i & next_irq_enable & next_irq_flag;
         // R17 reset from synchronised time-out, one cycle long
         system_reset <= to_reset;
      end
   end

   assign prdata_o = prdata;
   assign pready_o = pready;
   assign pslverr_o = pslverr;
   assign timeout_irq_o = timeout_irq;
   assign system_reset_o = system_reset;

endmodule

// [src/wdt_pkg.sv]
// Shared constants, field layout and mode type of the watchdog timer control block
package wdt_pkg;

   // Register byte addresses on the APB window
   localparam logic [11:0] CTRL_STATUS_ADDR = 12'h000;
   localparam logic [11:0] RESET_CAUSE_ADDR = 12'h004;

   // Field positions in watchdog_control_status
   localparam int IRQ_FLAG_BIT = 7;
   localparam int IRQ_ENABLE_BIT = 6;
   localparam int PERIOD_HI_BIT = 5;
   localparam int UNLOCK_BIT = 4;
   localparam int RESET_ENABLE_BIT = 3;
   localparam int PERIOD_LO_MSB = 2;

   // Field position in reset_cause_register
   localparam int CAUSE_FLAG_BIT = 3;

   // Reset values
   localparam logic [3:0] PERIOD_SELECT_RESET = 4'h0;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   // Highest valid period code; reserved codes above it fall back to it
   localparam logic [3:0] PERIOD_SELECT_MAX = 4'h9;

   // Unlock window length in CPU clock cycles
   localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
   localparam logic [2:0] UNLOCK_LAST = 3'h1;

   // Oscillator cycles at period code zero, and counter width
   localparam int unsigned TIMEOUT_BASE_CYCLES = 2048;
   localparam int COUNT_WIDTH = 20;
   typedef logic [COUNT_WIDTH-1:0] count_t;

   // Nominal watchdog oscillator rate, kHz
   localparam int OSC_FREQ_KHZ = 128;

   // Operating mode, coded as {reset enable, interrupt enable}
   typedef enum logic [1:0]
   {
      MODE_STOPPED = 2'b00,
      MODE_IRQ = 2'b01,
      MODE_RESET = 2'b10,
      MODE_IRQ_RESET = 2'b11
   } mode_e;

endpackage

// [testbench/core_model.sv]
// Processor core stand-in that takes the watchdog vector
`timescale 1ns/1ps
module core_model (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // Bench control
   input wire logic take_en_i,
   input wire logic [2:0] delay_i,
   // Watchdog side
   input wire logic irq_i,
   output logic taken_o
);
   logic [2:0] wait_cnt;
   // vector taken pulse
   // Idle cycle after a pulse lets the request fall first
   always_ff @(posedge mclk_i)
   begin
      if (!reset_n_i || taken_o)
      begin
         taken_o <= 1'b0;
         wait_cnt <= 3'h0;
      end
      else if (irq_i && take_en_i)
      begin
         taken_o <= wait_cnt == delay_i;
         wait_cnt <= wait_cnt + 3'h1;
      end
      else
         wait_cnt <= 3'h0;
   end
endmodule

// [testbench/testbench.sv]
// Self-checking bench of the watchdog control block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin mismatches++; \
   $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module testbench;
   localparam int unsigned BASE = 4;
   logic mclk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h00000000;
   logic [3:0] pstrb_i = 4'h0;
   logic [31:0] prdata_o;
   logic pready_o;
   logic pslverr_o;
   logic gie = 1'b0;
   logic taken;
   logic kick = 1'b0;
   logic kick_req = 1'b0;
   logic auto_kick = 1'b0;
   logic [2:0] tick = 3'h0;
   logic irq;
   logic fuse = 1'b0;
   logic osc = 1'b0;
   logic sys_rst;
   logic take_en = 1'b0;
   logic [2:0] take_dly = 3'h0;
   logic [32:0] notes[$];
   logic [32:0] note;
   logic [31:0] seed = 32'h4997901D;
   int mismatches = 0;
   int num_checks = 0;

   watchdog_timer_control #(.TIMEOUT_BASE_CYCLES(BASE)) dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .global_irq_enable_i(gie), .irq_vector_taken_i(taken), .kick_instruction_i(kick),
      .timeout_irq_o(irq), .always_on_fuse_i(fuse), .wdt_osc_i(osc), .system_reset_o(sys_rst));
   core_model core (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .take_en_i(take_en), .delay_i(take_dly),
      .irq_i(irq), .taken_o(taken));

   // Core clock, and an oscillator of unrelated period
   always #10 mclk_i = ~mclk_i;
   always #85 osc = ~osc;

   // Kicks on request, or every eighth cycle to hold time-outs off
   always @(posedge mclk_i)
   begin
      tick <= tick + 3'h1;
      kick <= kick_req | (auto_kick & (tick == 3'h0));
   end

   // Each bus answer is matched with the oldest note
   always @(posedge mclk_i)
   begin
      if (pready_o === 1'b1)
      begin
         note = notes.pop_front();
         `CHK("prdata", note[31:0], prdata_o)
         `CHK("pslverr", note[32], pslverr_o)
      end
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // One APB transfer; unused data bits carry noise
   task automatic apb(input logic wr, input logic [11:0] ad, input logic [7:0] wd, input logic [3:0] st,
      input logic [7:0] ex);
      int k;
      logic [31:0] r;
      r = rnd();
      notes.push_back({ad != wdt_pkg::CTRL_STATUS_ADDR && ad != wdt_pkg::RESET_CAUSE_ADDR, 24'h000000, ex});
      @(posedge mclk_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= ad;
      pwdata_i <= {r[31:8], wd};
      pstrb_i <= st;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      k = 0;
      do
      begin
         @(posedge mclk_i);
         k++;
      end
      while (pready_o !== 1'b1 && k < 20);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      if (k >= 20)
      begin
         mismatches++;
         complete_run();
      end
   endtask

   task automatic wc(input logic [7:0] d);
      apb(1'b1, wdt_pkg::CTRL_STATUS_ADDR, d, 4'hF, 8'h00);
   endtask

   task automatic rc(input logic [7:0] e);
      apb(1'b0, wdt_pkg::CTRL_STATUS_ADDR, 8'h00, 4'hF, e);
   endtask

   // Unlock, then reconfigure at once
   task automatic cfg(input logic [7:0] d);
      wc(8'h18);
      wc(d);
   endtask

   task automatic kick1();
      kick_req <= 1'b1;
      @(posedge mclk_i);
      kick_req <= 1'b0;
   endtask

   // Bounded wait for an interrupt (sel 0) or a reset pulse (sel 1)
   task automatic wait_ev(input logic sel, input int bound, output int n);
      n = 0;
      do
      begin
         @(posedge mclk_i);
         n++;
      end
      while ((sel ? sys_rst : irq) !== 1'b1 && n < bound);
      if (n >= bound)
      begin
         mismatches++;
         complete_run();
      end
   endtask

   // Interrupt mode at one code; time from kick to request
   task automatic period_chk(input logic [3:0] code);
      int n;
      int e;
      logic [31:0] r;
      e = BASE << ((code > 4'h9) ? 4'h9 : code);
      r = rnd();
      take_dly <= r[2:0];
      auto_kick <= 1'b1;
      cfg({2'b01, code[3], 2'b00, code[2:0]});
      auto_kick <= 1'b0;
      kick1();
      repeat (12) @(posedge mclk_i);
      wait_ev(1'b0, e * 9 + 40, n);
      `CHK("period", 1'b1, (n + 12) * 2 >= e * 17 - 20 && (n + 12) * 2 <= e * 17 + 50)
      // Let the core take the vector before the next unlock write drops the enable
      repeat (10) @(posedge mclk_i);
   endtask

   initial
   begin
      int n;
      repeat (3) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      auto_kick <= 1'b1;
      // Reset values, unmapped places, masked strobe
      rc(8'h00);
      apb(1'b0, wdt_pkg::RESET_CAUSE_ADDR, 8'h00, 4'hF, 8'h00);
      apb(1'b0, 12'h008, 8'h00, 4'hF, 8'h00);
      apb(1'b1, 12'h00C, 8'hFF, 4'hF, 8'h00);
      apb(1'b1, wdt_pkg::CTRL_STATUS_ADDR, 8'h08, 4'h0, 8'h00);
      rc(8'h00);
      // Reset enable sets freely, clears only unlocked
      wc(8'h08);
      wc(8'h01);
      rc(8'h08);
      // Last edge of the unlock window still counts
      wc(8'h18);
      @(posedge mclk_i);
      wc(8'h00);
      rc(8'h00);
      // One edge later it has closed
      wc(8'h08);
      wc(8'h18);
      repeat (2) @(posedge mclk_i);
      wc(8'h00);
      rc(8'h08);
      // Flag sets while masked and clears only on a one
      cfg(8'h40);
      auto_kick <= 1'b0;
      repeat (80) @(posedge mclk_i);
      `CHK("masked irq", 1'b0, irq)
      kick1();
      wc(8'h40);
      rc(8'hC0);
      wc(8'hC0);
      rc(8'h40);
      gie <= 1'b1;
      take_en <= 1'b1;
      period_chk(4'h0);
      period_chk(4'h1);
      period_chk(4'hF);
      // Combined mode: vector drops flag and enable
      auto_kick <= 1'b1;
      cfg(8'h48);
      auto_kick <= 1'b0;
      wait_ev(1'b0, 80, n);
      repeat (12) @(posedge mclk_i);
      rc(8'h08);
      // Re-armed outside the handler, then left unserviced
      take_en <= 1'b0;
      wc(8'h48);
      wait_ev(1'b0, 80, n);
      wait_ev(1'b1, 80, n);
      `CHK("reset gap", 1'b1, n > 20)
      // Cause flag holds the reset enable until cleared
      auto_kick <= 1'b1;
      apb(1'b0, wdt_pkg::RESET_CAUSE_ADDR, 8'h00, 4'hF, 8'h08);
      cfg(8'h00);
      rc(8'h08);
      apb(1'b1, wdt_pkg::RESET_CAUSE_ADDR, 8'h00, 4'hF, 8'h00);
      apb(1'b0, wdt_pkg::RESET_CAUSE_ADDR, 8'h00, 4'hF, 8'h00);
      // Enable was held at one, so it stays set until an unlocked clear
      rc(8'h08);
      cfg(8'h00);
      rc(8'h00);
      // Fuse forces reset mode from power-on
      reset_n_i <= 1'b0;
      fuse <= 1'b1;
      auto_kick <= 1'b0;
      repeat (3) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      rc(8'h08);
      wc(8'h40);
      wait_ev(1'b1, 80, n);
      `CHK("fuse irq", 1'b0, irq)
      complete_run();
   end
endmodule

bind watchdog_timer_control wdt_checker u_chk (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .global_irq_enable_i(global_irq_enable_i), .irq_vector_taken_i(irq_vector_taken_i),
   .always_on_fuse_i(always_on_fuse_i), .timeout_irq_o(timeout_irq_o), .system_reset_o(system_reset_o));

// [testbench/wdt_checker_assertions.sv]
// Port assertions of the watchdog control block
`timescale 1ns/1ps
module wdt_checker (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // Core, fuse and reset out
   input wire logic global_irq_enable_i,
   input wire logic irq_vector_taken_i,
   input wire logic always_on_fuse_i,
   input wire logic timeout_irq_o,
   input wire logic system_reset_o
);
   wire unmapped = paddr_i != wdt_pkg::CTRL_STATUS_ADDR && paddr_i != wdt_pkg::RESET_CAUSE_ADDR;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   // Bus answers
   AST_READY_AFTER_SETUP: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o)
      else $error("pready late or long");
   AST_UNMAPPED_ERR: assert property (psel_i && !penable_i && unmapped |=> pslverr_o && prdata_o == 32'h00000000)
      else $error("unmapped access not refused");
   AST_MAPPED_OK: assert property (psel_i && !penable_i && !unmapped |=> !pslverr_o && prdata_o[31:8] == 24'h000000)
      else $error("mapped access refused");
   // Interrupt request
   AST_IRQ_NEEDS_GIE: assert property (!global_irq_enable_i |=> !timeout_irq_o)
      else $error("irq without global enable");
   AST_IRQ_HOLDS: assert property (timeout_irq_o && global_irq_enable_i && !irq_vector_taken_i
      && !(psel_i && penable_i && pwrite_i) && !system_reset_o |=> timeout_irq_o)
      else $error("irq dropped on its own");
   AST_ACK_CLEARS: assert property (timeout_irq_o && irq_vector_taken_i |=> !timeout_irq_o)
      else $error("irq kept after vector");
   // Reset pulse and fuse
   AST_RESET_PULSE: assert property (system_reset_o |=> !system_reset_o [*8])
      else $error("reset pulse too long or repeated");
   AST_FUSE_NO_IRQ: assert property (always_on_fuse_i && !timeout_irq_o |=> !timeout_irq_o)
      else $error("irq with fuse programmed");
endmodule
